// ### bench/rx_backplane_model.sv
// Backplane equipment model: serial clock, frame sync and line data
`timescale 1ns/1ps
`default_nettype none
module rx_backplane_model (
  input wire logic clk_oe,
  input wire logic link_clk,
  output logic bp_clk,
  output logic line_data,
  output logic sync_drv,
  output logic [63:0] hist
);
  logic fclk;
  logic run;
  logic [7:0] cnt;
  initial begin
    fclk = 1'b0;
    run = 1'b0;
    cnt = 8'h00;
    line_data = 1'b0;
    sync_drv = 1'b0;
    hist = '0;
    #7;
    forever #15 fclk = ~fclk;
  end
  // Gate in the low phase so the supplied clock never glitches
  always @(negedge fclk) run <= ~clk_oe;
  assign bp_clk = fclk & run;
  // Data and sync move on the link clock itself, so they stay in step
  always @(posedge link_clk) begin
    cnt <= cnt + 8'h01;
    line_data <= cnt[0] ^ cnt[2] ^ cnt[5];
    sync_drv <= (cnt == 8'hff);
    hist <= {hist[62:0], line_data};
  end
endmodule
`default_nettype wire

// ### bench/rx_slip_buffer_mode_control_tb.sv
// Testbench for the receive slip buffer mode control
`timescale 1ns/1ps
`default_nettype none
module rx_slip_buffer_mode_control_tb;
  import rx_slip_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] aa = '0;
  logic [11:0] ra = '0;
  logic [31:0] wd = '0;
  logic av = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic rv = 1'b0;
  logic rr = 1'b0;
  wire logic ar_q, wr_q, bv, rdy_r, rval, co, coe, so, soe, ser, ld, bpc, sd;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [63:0] hist;
  wire logic lclk = coe ? co : bpc;
  wire logic sync_pin = soe ? so : sd;
  int errors = 0;
  int samples_checked = 0;
  always #2.5 aclk = ~aclk;
  rx_slip_buffer_mode_control u_rx_slip_buffer_mode_control (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aa), .s_axi_awprot(3'h0), .s_axi_awvalid(av),
    .s_axi_awready(ar_q), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_q), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ra),
    .s_axi_arprot(3'h0), .s_axi_arvalid(rv), .s_axi_arready(rdy_r),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rval),
    .s_axi_rready(rr), .rx_backplane_clk(lclk),
    .rx_backplane_clk_out(co), .rx_backplane_clk_oe(coe),
    .rx_frame_sync_in(sync_pin), .rx_frame_sync_out(so),
    .rx_frame_sync_oe(soe), .rx_line_data(ld), .rx_serial_data(ser));
  rx_backplane_model u_rx_backplane_model (
    .clk_oe(coe), .link_clk(lclk), .bp_clk(bpc), .line_data(ld),
    .sync_drv(sd), .hist(hist));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    @(posedge aclk);
    aa <= a;
    wd <= d;
    av <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (ar_q) av <= 1'b0;
      if (wr_q) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    if (n == 50) errors++;
    chk(32'(bresp), 32'(er));
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int n;
    @(posedge aclk);
    ra <= a;
    rv <= 1'b1;
    rr <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (rdy_r) rv <= 1'b0;
      if (rval) break;
    end
    rr <= 1'b0;
    if (n == 50) errors++;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask
  task automatic t_reset();
    axr(SBC_ADDR, 32'h04, RESP_OKAY);
    axr(LAT_ADDR, 32'h04, RESP_OKAY);
    chk(32'(coe), 32'h1);
    chk(32'(soe), 32'h1);
  endtask
  task automatic t_fields();
    axw(SBC_ADDR, 32'hff, RESP_OKAY);
    axr(SBC_ADDR, 32'h9f, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(soe), 32'h1);
    axw(LAT_ADDR, 32'hff, RESP_OKAY);
    axr(LAT_ADDR, 32'h1f, RESP_OKAY);
    axw(12'h000, 32'h55, RESP_SLVERR);
    axr(12'h000, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_dirs();
    logic byp;
    for (int m = 0; m < 4; m++) begin
      for (int s = 0; s < 2; s++) begin
        byp = (m == 0) || (m == 3);
        axw(SBC_ADDR, 32'(s * 4 + m), RESP_OKAY);
        repeat (2) @(posedge aclk);
        #1;
        chk(32'(coe), 32'(byp));
        chk(32'(soe), 32'(byp | (s == 0)));
      end
    end
  endtask
  // Mode and latency set, then output compared with the delayed input
  task automatic t_delay(input logic [1:0] m, input logic [4:0] lat,
                         input int d);
    axw(LAT_ADDR, 32'(lat), RESP_OKAY);
    axw(SBC_ADDR, 32'(m), RESP_OKAY);
    repeat (1000) @(posedge aclk);
    repeat (24) begin
      @(negedge lclk);
      chk(32'(ser), 32'(hist[d]));
    end
  endtask
  // Bypass clock period measured between two rising edges
  task automatic t_clk();
    realtime t0;
    @(posedge co);
    t0 = $realtime;
    @(posedge co);
    chk(32'(int'($realtime - t0)), 32'(CLK_HALF_CYCLES * 10));
  endtask
  // Frame sync spacing as an output, silence as an input, then status
  task automatic t_sync();
    int n;
    axw(SBC_ADDR, 32'(MODE_SLIP), RESP_OKAY);
    repeat (50) @(posedge aclk);
    n = 0;
    while (so !== 1'b1 && n < 600) begin
      @(negedge lclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge lclk);
      n++;
    end while (so !== 1'b1 && n < 600);
    chk(32'(n), 32'(FRAME_LAST_BIT) + 32'h1);
    axw(SBC_ADDR, 32'(MODE_SLIP) | (32'h1 << SBC_SDIR_BIT), RESP_OKAY);
    repeat (20) @(negedge lclk);
    n = 0;
    repeat (300) begin
      @(negedge lclk);
      if (so !== 1'b0) n++;
    end
    chk(32'(n), 32'h0);
    axr(STAT_ADDR, 32'h1, RESP_OKAY);
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    t_reset();
    t_fields();
    t_dirs();
    t_delay(MODE_BYPASS_A, 5'h1f, 2);
    t_delay(MODE_SLIP, 5'h1f, 2);
    t_delay(MODE_FIFO, 5'h00, 2);
    t_delay(MODE_FIFO, 5'h04, 6);
    t_delay(MODE_FIFO, 5'h1f, 33);
    t_delay(MODE_BYPASS_B, 5'h04, 2);
    t_clk();
    t_sync();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### hdl/rx_slip_buffer_mode_control.sv
// Receive slip buffer mode control with AXI4-Lite registers
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Mode 00 or 11 bypasses buffer; clock and sync pins are outputs.
// - Mode 01 is slip buffer, 10 is FIFO; clock pin becomes input.
// - In slip or FIFO mode, sync pin direction follows bit 2: 0 out, 1 in.
// - Pin directions chosen by mode apply one register clock cycle after the register changes.
// - FIFO mode delays data by the five-bit latency, reset value 00100.
// - Latency field has no effect on timing outside FIFO mode.
// - In bypass the sync pin is always an output, whatever bit 2 says.
module rx_slip_buffer_mode_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [rx_slip_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rx_slip_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_backplane_clk,
  output logic rx_backplane_clk_out,
  output logic rx_backplane_clk_oe,
  input wire logic rx_frame_sync_in,
  output logic rx_frame_sync_out,
  output logic rx_frame_sync_oe,
  input wire logic rx_line_data,
  output logic rx_serial_data
);
  import rx_slip_pkg::*;

  // Register storage
  logic [7:0] sbc_q;
  logic [4:0] lat_q;

  // AXI write path
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  wire w_full_d = (w_full_q | w_take) & ~wr_fire;
  wire wr_sbc = wr_fire & (waddr_q == SBC_ADDR) & wstrb0_q;
  wire wr_lat = wr_fire & (waddr_q == LAT_ADDR) & wstrb0_q;
  wire wr_known = (waddr_q == SBC_ADDR) | (waddr_q == LAT_ADDR) |
                  (waddr_q == STAT_ADDR);
  wire bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      bvalid_q <= bvalid_d;
      if (wr_fire) begin
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_take) begin
        waddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // Reserved bits 6:5 are not stored and read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sbc_q <= SBC_RESET;
      lat_q <= LAT_RESET;
    end else begin
      if (wr_sbc) begin
        sbc_q <= {wdata_q[SBC_KEEP_HI_BIT], 2'h0,
                  wdata_q[SBC_KEEP_LO_MSB:0]};
      end
      if (wr_lat) begin
        lat_q <= wdata_q[LAT_MSB:0];
      end
    end
  end

  // Configuration as software sees it
  wire [1:0] mode_live = sbc_q[SBC_MODE_LSB +: 2];
  wire sdir_live = sbc_q[SBC_SDIR_BIT];
  wire bypass_live = is_bypass(mode_live);
  wire rx_cfg_s cfg_live = '{mode: mode_live, sync_dir: sdir_live,
                             latency: lat_q};

  // Handshake carrying the configuration word to the link domain
  rx_cfg_s cfg_hold_q;
  logic req_q, ack_s1_q, ack_s2_q;
  logic l_ack_q;
  wire cfg_idle = (req_q == ack_s2_q);
  wire cfg_applied = cfg_idle & (cfg_hold_q == cfg_live);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_hold_q <= CFG_RESET;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= l_ack_q;
      ack_s2_q <= ack_s1_q;
      if (cfg_idle && (cfg_hold_q != cfg_live)) begin
        cfg_hold_q <= cfg_live;
        req_q <= ~req_q;
      end
    end
  end

  // Pin directions and the clock driven out while bypassed
  logic clk_oe_q, sync_oe_q, clk_out_q;
  logic [5:0] div_q;
  wire div_wrap = (div_q == CLK_HALF_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_oe_q <= 1'b1;
      sync_oe_q <= 1'b1;
      clk_out_q <= 1'b0;
      div_q <= '0;
    end else begin
      clk_oe_q <= bypass_live;
      sync_oe_q <= bypass_live | ~sdir_live;
      if (!bypass_live) begin
        clk_out_q <= 1'b0;
        div_q <= '0;
      end else if (div_wrap) begin
        clk_out_q <= ~clk_out_q;
        div_q <= '0;
      end else begin
        div_q <= div_q + 6'h01;
      end
    end
  end

  // AXI read path
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire sel_sbc = (s_axi_araddr == SBC_ADDR);
  wire sel_lat = (s_axi_araddr == LAT_ADDR);
  wire sel_stat = (s_axi_araddr == STAT_ADDR);
  wire [31:0] stat_word = {29'h0, sync_oe_q, clk_oe_q, cfg_applied};
  wire [31:0] rd_word = sel_sbc ? {24'h0, sbc_q} :
                        sel_lat ? {27'h0, lat_q} :
                        sel_stat ? stat_word : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= (sel_sbc | sel_lat | sel_stat) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Link reset stretched past release: the bypass clock is still in reset
  // while aresetn is low, so the link side would never see it
  logic [9:0] lrst_cnt_q;
  logic lrst_n_q;
  wire lrst_done = (lrst_cnt_q == LINK_RST_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lrst_cnt_q <= '0;
      lrst_n_q <= 1'b0;
    end else begin
      if (!lrst_done) begin
        lrst_cnt_q <= lrst_cnt_q + 10'h001;
      end
      lrst_n_q <= lrst_done;
    end
  end

  // Link domain on the backplane clock pin
  logic l_rst_s1_q, l_rst_s2_q;
  logic l_req_s1_q, l_req_s2_q, l_req_s3_q;
  logic l_din_s1_q, l_din_s2_q, l_sync_s1_q, l_sync_s2_q, l_sync_old_q;
  rx_cfg_s l_cfg_q;
  logic [31:0] dly_q;
  logic [7:0] bit_q;
  logic sync_out_q, rx_data_q;
  wire l_fifo = is_fifo(l_cfg_q.mode);
  wire l_sync_is_in = ~is_bypass(l_cfg_q.mode) & l_cfg_q.sync_dir;
  wire l_sync_rise = l_sync_s2_q & ~l_sync_old_q;
  wire l_tap = (l_cfg_q.latency == 5'h00) ? l_din_s2_q :
               dly_q[l_cfg_q.latency - 5'h01];

  always_ff @(posedge rx_backplane_clk) begin
    l_rst_s1_q <= lrst_n_q;
    l_rst_s2_q <= l_rst_s1_q;
    l_req_s1_q <= req_q;
    l_req_s2_q <= l_req_s1_q;
    l_din_s1_q <= rx_line_data;
    l_din_s2_q <= l_din_s1_q;
    l_sync_s1_q <= rx_frame_sync_in;
    l_sync_s2_q <= l_sync_s1_q;
  end

  always_ff @(posedge rx_backplane_clk) begin
    if (!l_rst_s2_q) begin
      l_req_s3_q <= 1'b0;
      l_ack_q <= 1'b0;
      l_cfg_q <= CFG_RESET;
      l_sync_old_q <= 1'b0;
      dly_q <= '0;
      bit_q <= '0;
      sync_out_q <= 1'b0;
      rx_data_q <= 1'b0;
    end else begin
      l_req_s3_q <= l_req_s2_q;
      l_ack_q <= l_req_s2_q;
      if (l_req_s2_q != l_req_s3_q) begin
        l_cfg_q <= cfg_hold_q;
      end
      l_sync_old_q <= l_sync_s2_q;
      dly_q <= {dly_q[30:0], l_din_s2_q};
      if (l_sync_is_in && l_sync_rise) begin
        bit_q <= SYNC_ALIGN_BIT;
      end else begin
        bit_q <= bit_q + 8'h01;
      end
      sync_out_q <= ~l_sync_is_in & (bit_q == FRAME_LAST_BIT);
      rx_data_q <= l_fifo ? l_tap : l_din_s2_q;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign rx_backplane_clk_out = clk_out_q;
  assign rx_backplane_clk_oe = clk_oe_q;
  assign rx_frame_sync_out = sync_out_q;
  assign rx_frame_sync_oe = sync_oe_q;
  assign rx_serial_data = rx_data_q;

  // Checks in the register clock domain
  sequence s_wr_both;
    aw_take && w_take && !aw_full_q && !w_full_q && !bvalid_q;
  endsequence

  sequence s_wr_answer;
    ##2 bvalid_q;
  endsequence

  a_write_answer_two: assert property (
    @(posedge aclk) disable iff (!aresetn) s_wr_both |-> s_wr_answer
  ) else $error("write response not two cycles after address and data");

  a_read_answer_next: assert property (
    @(posedge aclk) disable iff (!aresetn) ar_take |=> rvalid_q
  ) else $error("read data not one cycle after address");

  a_bypass_clk_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    is_bypass(sbc_q[1:0]) |=> rx_backplane_clk_oe
  ) else $error("clock pin not driven while bypassed");

  a_buffer_clk_input: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (sbc_q[1:0] == MODE_SLIP || sbc_q[1:0] == MODE_FIFO)
    |=> !rx_backplane_clk_oe
  ) else $error("clock pin driven while buffer in use");

  a_sync_dir_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !is_bypass(sbc_q[1:0]) |=> (rx_frame_sync_oe == !$past(sbc_q[2]))
  ) else $error("sync pin direction does not follow select bit");

  a_bypass_sync_out: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (is_bypass(sbc_q[1:0]) && sbc_q[2]) |=> rx_frame_sync_oe
  ) else $error("sync pin not driven while bypassed");

  a_clk_half_period: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (bypass_live && $changed(clk_out_q)) |-> $past(div_q) == CLK_HALF_LAST
  ) else $error("bypass clock half period wrong");

  // Checks in the link clock domain
  a_fifo_latency_four: assert property (
    @(posedge rx_backplane_clk) disable iff (!l_rst_s2_q)
    (l_fifo && l_cfg_q.latency == 5'h04 && $past(l_rst_s2_q, 5))
    |=> rx_serial_data == $past(l_din_s2_q, 5)
  ) else $error("fifo data not delayed by four periods");

  a_latency_ignored: assert property (
    @(posedge rx_backplane_clk) disable iff (!l_rst_s2_q)
    !l_fifo |=> rx_serial_data == $past(l_din_s2_q)
  ) else $error("latency affected data outside fifo mode");

  a_sync_in_quiet: assert property (
    @(posedge rx_backplane_clk) disable iff (!l_rst_s2_q)
    l_sync_is_in |=> !rx_frame_sync_out
  ) else $error("sync pulse driven while sync pin is an input");

endmodule

`default_nettype wire

// ### hdl/rx_slip_pkg.sv
// Constants, types and helpers for the receive slip buffer mode control
package rx_slip_pkg;

  // Register indexes as printed; each register is one 32-bit word
  localparam int unsigned SBC_INDEX = 'h116;
  localparam int unsigned LAT_INDEX = 'h117;
  localparam int unsigned STAT_INDEX = 'h118;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] SBC_ADDR = 12'(SBC_INDEX * 4);
  localparam logic [11:0] LAT_ADDR = 12'(LAT_INDEX * 4);
  localparam logic [11:0] STAT_ADDR = 12'(STAT_INDEX * 4);

  // Field positions
  localparam int unsigned SBC_MODE_LSB = 0;
  localparam int unsigned SBC_SDIR_BIT = 2;
  localparam int unsigned SBC_KEEP_LO_MSB = 4;
  localparam int unsigned SBC_KEEP_HI_BIT = 7;
  localparam int unsigned LAT_MSB = 4;
  localparam int unsigned STAT_APPLIED_BIT = 0;
  localparam int unsigned STAT_CLKDIR_BIT = 1;
  localparam int unsigned STAT_SYNCDIR_BIT = 2;

  // Values after reset
  localparam logic [7:0] SBC_RESET = 8'h04;
  localparam logic [4:0] LAT_RESET = 5'h04;

  // Mode field encodings
  localparam logic [1:0] MODE_BYPASS_A = 2'h0;
  localparam logic [1:0] MODE_SLIP = 2'h1;
  localparam logic [1:0] MODE_FIFO = 2'h2;
  localparam logic [1:0] MODE_BYPASS_B = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: base backplane rate and the clock driven out in bypass
  localparam int unsigned ACLK_KHZ = 200000;
  localparam int unsigned BASE_RATE_KHZ = 2048;
  localparam int unsigned CLK_HALF_CYCLES = ACLK_KHZ / (2 * BASE_RATE_KHZ);
  localparam logic [5:0] CLK_HALF_LAST = 6'(CLK_HALF_CYCLES - 1);
  // Link reset held for eight bypass clock periods after release
  localparam logic [9:0] LINK_RST_LAST = 10'(16 * CLK_HALF_CYCLES);
  localparam logic [7:0] FRAME_LAST_BIT = 8'hff;
  localparam logic [7:0] SYNC_ALIGN_BIT = 8'h01;

  typedef struct packed {
    logic [1:0] mode;
    logic sync_dir;
    logic [4:0] latency;
  } rx_cfg_s;

  localparam rx_cfg_s CFG_RESET = '{
    mode: SBC_RESET[1:0],
    sync_dir: SBC_RESET[2],
    latency: LAT_RESET
  };

  function automatic logic is_bypass(input logic [1:0] mode);
    return (mode == MODE_BYPASS_A) || (mode == MODE_BYPASS_B);
  endfunction

  function automatic logic is_fifo(input logic [1:0] mode);
    return mode == MODE_FIFO;
  endfunction

endpackage
